// ===== rtl/dlt_delay_timers.sv
// Functional notes
// - Stopwatch counts up while enabled
// - Stopwatch clear forces count to zero
// - Stopwatch output when count reaches preset
// - Stopwatch freezes count and output when disabled
// - Stopwatch resumes from frozen count
// - Clear drops stopwatch output unless preset <= 0
// - Unit of 0.1, 0.01 or 0.001 s
// - On-delay defaults to tenths
// - Count saturates at 32767
// - Three consecutive words per timer
// - Preset loaded from operand on enable/clear
// - One shared state per timer
// - No power-up initialisation of timer data
// - Disabled on-delay holds zero, output off
// - On-delay output only enabled and reached
// - Enabled off-delay: output on for preset > 0, count zero
// - Off-delay counts after enable drops
// - Off-delay output drops at preset, stops
// - Off-delay never on with preset <= 0
// - Off-delay count cleared when re-enabled
// - Off-delay accrues all real elapsed time
// - Saturated stopwatch holds count and output
// - Control word low bits hold fraction
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
module dlt_delay_timers #(
  parameter int FINE_CYCLES = dlt_pkg::FINE_CYCLES_DFLT   // Clocks per fine tick
) (
  input  wire logic                                     clk,
  input  wire logic                                     reset_n,
  input  wire dlt_pkg::dlt_bus_req_t                    busReq,
  output logic             [dlt_pkg::DATA_W-1:0]        rdData,
  input  wire dlt_pkg::dlt_tmr_in_t [dlt_pkg::NUM_TMR-1:0] tmrIn,
  output logic             [dlt_pkg::NUM_TMR-1:0]       tmrOut
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  typedef struct packed {
    dlt_pkg::dlt_timer_t [dlt_pkg::NUM_TMR-1:0] tmr;       // Timer storage
    logic [2*dlt_pkg::NUM_TMR-1:0]              unitCfg;   // Unit select per timer
    logic [dlt_pkg::DATA_W-1:0]                 rdata;     // Read data
  } dlt_state_t;

  localparam int SW  = dlt_pkg::TMR_STOPWATCH;          // Slot shorthands
  localparam int OND = dlt_pkg::TMR_ONDELAY;
  localparam int OFD = dlt_pkg::TMR_OFFDELAY;

  dlt_state_t                  st_r;                    // Registered state
  dlt_state_t                  st_nxt;                  // Next state
  dlt_pkg::dlt_dec_t           dec;                     // Decoded bus address
  logic                        fineTick;                // Shared fine time base
  logic [dlt_pkg::NUM_TMR-1:0] run;                     // Prescaler may advance
  logic [dlt_pkg::NUM_TMR-1:0] fracClr;                 // Prescaler clear
  logic [dlt_pkg::NUM_TMR-1:0] unitTick;                // One count unit elapsed
  logic [dlt_pkg::FRAC_W-1:0]  frac [dlt_pkg::NUM_TMR]; // Sub-unit fractions
  logic [dlt_pkg::NUM_TMR-1:0] cntWr;                   // Software writes a count

  ////////////////////////////////////////////////////////////////////////////////
  // Time base and prescalers

  // Shared fine tick generator
  dlt_tick_gen #(
    .FINE_CYCLES (FINE_CYCLES)
  ) u_tick (
    .clk      (clk),
    .reset_n  (reset_n),
    .fineTick (fineTick)
  );

  // One prescaler per timer, fed by its own unit select
  for (genvar g = 0; g < dlt_pkg::NUM_TMR; g++) begin : g_scale
    dlt_frac_scaler u_scale (
      .clk      (clk),
      .reset_n  (reset_n),
      .fineTick (fineTick),
      .unitSel  (st_r.unitCfg[2*g +: 2]),
      .run      (run[g]),
      .clear    (fracClr[g]),
      .frac     (frac[g]),
      .unitTick (unitTick[g])
    );
    assign tmrOut[g] = st_r.tmr[g].flag;
  end

  // When each prescaler may run and when its fraction restarts
  always_comb begin
    // Stopwatch: runs while enabled, not cleared, below saturation
    run[SW]      = tmrIn[SW].en & ~tmrIn[SW].clr
                   & (st_r.tmr[SW].cnt != dlt_pkg::COUNT_MAX);
    fracClr[SW]  = tmrIn[SW].clr;
    // On-delay: runs while enabled, fraction dropped when disabled
    run[OND]     = tmrIn[OND].en
                   & (st_r.tmr[OND].cnt != dlt_pkg::COUNT_MAX);
    fracClr[OND] = ~tmrIn[OND].en;
    // Off-delay: runs after enable drops until the preset is reached
    run[OFD]     = ~tmrIn[OFD].en & st_r.tmr[OFD].flag
                   & ~dlt_pkg::geq(st_r.tmr[OFD].cnt, st_r.tmr[OFD].pv);
    fracClr[OFD] = tmrIn[OFD].en;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    dec    = dlt_pkg::addr_decode(busReq.addr);
    st_nxt = st_r;

    // Sample inputs and load presets from the operand
    for (int i = 0; i < dlt_pkg::NUM_TMR; i++) begin
      st_nxt.tmr[i].en  = tmrIn[i].en;
      st_nxt.tmr[i].clr = (i == SW) & tmrIn[i].clr;
      if (tmrIn[i].presetUse && (tmrIn[i].en || st_nxt.tmr[i].clr)) begin
        st_nxt.tmr[i].pv = tmrIn[i].preset;
      end
    end

    // Stopwatch count: clear first, otherwise advance on unit ticks
    if (tmrIn[SW].clr) begin
      st_nxt.tmr[SW].cnt = dlt_pkg::COUNT_RST;
    end else if (unitTick[SW]) begin
      st_nxt.tmr[SW].cnt = st_r.tmr[SW].cnt + 16'h0001;
    end
    // Otherwise the frozen count stays, even at saturation

    // On-delay count: zero when disabled
    if (!tmrIn[OND].en) begin
      st_nxt.tmr[OND].cnt = dlt_pkg::COUNT_RST;
    end else if (unitTick[OND]) begin
      st_nxt.tmr[OND].cnt = st_r.tmr[OND].cnt + 16'h0001;
    end

    // Off-delay count: zero while enabled, continuous real time after
    if (tmrIn[OFD].en) begin
      st_nxt.tmr[OFD].cnt = dlt_pkg::COUNT_RST;
    end else if (unitTick[OFD]) begin
      st_nxt.tmr[OFD].cnt = st_r.tmr[OFD].cnt + 16'h0001;
    end

    // Software writes to count, preset and unit select; control is read-only
    if (busReq.wr && dec.hitTmr) begin
      case (dec.word)
        dlt_pkg::WORD_COUNT: begin
          st_nxt.tmr[dec.idx].cnt = busReq.wdata;
        end
        dlt_pkg::WORD_PRESET: begin
          st_nxt.tmr[dec.idx].pv = busReq.wdata;
        end
        default: begin
        end
      endcase
    end else if (busReq.wr && dec.hitCfg) begin
      st_nxt.unitCfg = busReq.wdata[2*dlt_pkg::NUM_TMR-1:0];
    end

    // Output flags from the same-cycle count and preset
    st_nxt.tmr[SW].flag = dlt_pkg::geq(st_nxt.tmr[SW].cnt, st_nxt.tmr[SW].pv)
                          | (st_r.tmr[SW].flag & ~tmrIn[SW].en
                             & ~tmrIn[SW].clr);
    st_nxt.tmr[OND].flag = tmrIn[OND].en
                           & dlt_pkg::geq(st_nxt.tmr[OND].cnt, st_nxt.tmr[OND].pv);
    if (tmrIn[OFD].en) begin
      st_nxt.tmr[OFD].flag = ~dlt_pkg::geq(dlt_pkg::COUNT_RST, st_nxt.tmr[OFD].pv);
    end else begin
      st_nxt.tmr[OFD].flag = st_r.tmr[OFD].flag
                             & ~dlt_pkg::geq(st_nxt.tmr[OFD].cnt, st_nxt.tmr[OFD].pv)
                             & ~dlt_pkg::geq(dlt_pkg::COUNT_RST, st_nxt.tmr[OFD].pv);
    end

    // Read data: one cycle after the strobe, zero otherwise
    st_nxt.rdata = '0;
    if (busReq.rd && dec.hitTmr) begin
      case (dec.word)
        dlt_pkg::WORD_COUNT: begin
          st_nxt.rdata = st_r.tmr[dec.idx].cnt;
        end
        dlt_pkg::WORD_PRESET: begin
          st_nxt.rdata = st_r.tmr[dec.idx].pv;
        end
        default: begin
          st_nxt.rdata[dlt_pkg::FRAC_W-1:0]   = frac[dec.idx];
          st_nxt.rdata[dlt_pkg::CTL_EN_BIT]   = st_r.tmr[dec.idx].en;
          st_nxt.rdata[dlt_pkg::CTL_CLR_BIT]  = st_r.tmr[dec.idx].clr;
          st_nxt.rdata[dlt_pkg::CTL_OUT_BIT]  = st_r.tmr[dec.idx].flag;
        end
      endcase
    end else if (busReq.rd && dec.hitCfg) begin
      st_nxt.rdata[2*dlt_pkg::NUM_TMR-1:0] = st_r.unitCfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset is the only initialisation; nothing reloads timer data at start-up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  // Which timers see a software count write this cycle
  always_comb begin
    for (int i = 0; i < dlt_pkg::NUM_TMR; i++) begin
      cntWr[i] = busReq.wr & dec.hitTmr & (dec.idx == 2'(i))
                 & (dec.word == dlt_pkg::WORD_COUNT);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_offRise;
    !tmrIn[OFD].en ##1 tmrIn[OFD].en && !cntWr[OFD];
  endsequence

  sequence s_swHold;
    !tmrIn[SW].en && !tmrIn[SW].clr && !cntWr[SW];
  endsequence

  a_sw_clear_zero: assert property (
    tmrIn[SW].clr && !cntWr[SW] |=> st_r.tmr[SW].cnt == dlt_pkg::COUNT_RST)
    else $error("stopwatch clear did not zero count");

  // The reset value of the flag lags the compare by one cycle, so skip that cycle
  a_sw_flag_geq: assert property (
    dlt_pkg::geq(st_r.tmr[SW].cnt, st_r.tmr[SW].pv) && $past(reset_n) |-> tmrOut[SW])
    else $error("stopwatch flag low with count at preset");

  a_sw_freeze_hold: assert property (
    s_swHold |=> st_r.tmr[SW].cnt == $past(st_r.tmr[SW].cnt)
                 && (tmrOut[SW] || !$past(tmrOut[SW])))
    else $error("stopwatch changed while disabled");

  a_sw_step_one: assert property (
    unitTick[SW] && !tmrIn[SW].clr && !cntWr[SW]
    |=> st_r.tmr[SW].cnt == $past(st_r.tmr[SW].cnt) + 16'h0001)
    else $error("stopwatch did not step by one");

  a_sw_sat_hold: assert property (
    st_r.tmr[SW].cnt == dlt_pkg::COUNT_MAX && !tmrIn[SW].clr && !cntWr[SW]
    |=> st_r.tmr[SW].cnt == dlt_pkg::COUNT_MAX)
    else $error("stopwatch left saturation");

  a_on_idle_zero: assert property (
    !tmrIn[OND].en && !cntWr[OND] |=> st_r.tmr[OND].cnt == dlt_pkg::COUNT_RST
                                      && !tmrOut[OND])
    else $error("on-delay not idle when disabled");

  a_on_flag_cause: assert property (
    tmrOut[OND] |-> $past(tmrIn[OND].en)
                    && dlt_pkg::geq(st_r.tmr[OND].cnt, st_r.tmr[OND].pv))
    else $error("on-delay flag without cause");

  a_off_neg_preset: assert property (
    dlt_pkg::geq(dlt_pkg::COUNT_RST, st_r.tmr[OFD].pv) |-> !tmrOut[OFD])
    else $error("off-delay on with preset not positive");

  a_off_expire_low: assert property (
    !$past(tmrIn[OFD].en) && dlt_pkg::geq(st_r.tmr[OFD].cnt, st_r.tmr[OFD].pv)
    |-> !tmrOut[OFD] && !run[OFD])
    else $error("off-delay still on at preset");

  a_off_rise_clear: assert property (
    s_offRise |=> st_r.tmr[OFD].cnt == dlt_pkg::COUNT_RST)
    else $error("off-delay count not cleared on enable");

  // Clear leaves the flag set only for a preset that is not positive
  a_sw_clear_flag: assert property (
    tmrIn[SW].clr && !busReq.wr
    |=> tmrOut[SW] == dlt_pkg::geq(dlt_pkg::COUNT_RST, st_r.tmr[SW].pv))
    else $error("stopwatch flag wrong under clear");

  // Saturated stopwatch keeps its flag whatever enable does
  a_sw_sat_flag: assert property (
    st_r.tmr[SW].cnt == dlt_pkg::COUNT_MAX && !tmrIn[SW].clr && !busReq.wr
    |=> tmrOut[SW])
    else $error("stopwatch flag lost at saturation");

  // On-delay advances by exactly one per unit tick
  a_on_step_one: assert property (
    unitTick[OND] && !cntWr[OND]
    |=> st_r.tmr[OND].cnt == $past(st_r.tmr[OND].cnt) + 16'h0001)
    else $error("on-delay did not step by one");

  // Operand preset is copied while the timer is enabled
  a_preset_load: assert property (
    tmrIn[OND].presetUse && tmrIn[OND].en && !busReq.wr
    |=> st_r.tmr[OND].pv == $past(tmrIn[OND].preset))
    else $error("on-delay preset not loaded");

  // Enabled off-delay: count zero, flag set for a positive preset
  a_off_enabled_on: assert property (
    tmrIn[OFD].en && !cntWr[OFD]
    |=> st_r.tmr[OFD].cnt == dlt_pkg::COUNT_RST
        && (tmrOut[OFD] || dlt_pkg::geq(dlt_pkg::COUNT_RST, st_r.tmr[OFD].pv)))
    else $error("off-delay wrong while enabled");

  // A running off-delay stays on until a tick carries it to the preset
  a_off_run_hold: assert property (
    run[OFD] && !unitTick[OFD] && !busReq.wr |=> tmrOut[OFD])
    else $error("off-delay dropped early");

  // Unit ticks never come on two cycles in a row
  a_unit_tick_single: assert property (
    |unitTick |=> !(|(unitTick & $past(unitTick))))
    else $error("unit tick too wide");

  // Read data stands only in the cycle after a read strobe
  a_rd_idle_zero: assert property (
    !busReq.rd |=> rdData == '0)
    else $error("read data outside its cycle");

endmodule // dlt_delay_timers

// ===== common/dlt_pkg.sv
package dlt_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes and timer slots
  localparam int DATA_W       = 16;                 // Register word width
  localparam int ADDR_W       = 4;                  // Register word index width
  localparam int NUM_TMR      = 3;                  // Timer instances
  localparam int FRAC_W       = 12;                 // Sub-unit fraction width
  localparam int TMR_STOPWATCH = 0;                 // Retentive stopwatch slot
  localparam int TMR_ONDELAY  = 1;                  // Non-retentive on-delay slot
  localparam int TMR_OFFDELAY = 2;                  // Off-delay slot

  ////////////////////////////////////////////////////////////////////////////////
  // Register map (word indexes)
  localparam logic [ADDR_W-1:0] WORDS_PER_TMR = 4'h3;   // Words owned by each timer
  localparam logic [ADDR_W-1:0] TMR_WORDS_END = 4'h9;   // First index past timer words
  localparam logic [ADDR_W-1:0] OFF_UNIT_CFG  = 4'h9;   // Unit select register
  localparam logic [1:0]        WORD_COUNT    = 2'h0;   // Elapsed count word
  localparam logic [1:0]        WORD_PRESET   = 2'h1;   // Preset word
  localparam logic [1:0]        WORD_CTRL     = 2'h2;   // Control word

  ////////////////////////////////////////////////////////////////////////////////
  // Control word layout and values
  localparam int CTL_EN_BIT  = 12;                  // Last sampled enable
  localparam int CTL_CLR_BIT = 13;                  // Last sampled clear
  localparam int CTL_OUT_BIT = 14;                  // Output flag
  localparam logic [DATA_W-1:0] COUNT_MAX = 16'h7fff;   // Saturation value
  localparam logic [DATA_W-1:0] COUNT_RST = 16'h0000;   // Cleared count
  localparam logic [1:0] UNIT_TENTH      = 2'h0;    // 0.1 s units, default
  localparam logic [1:0] UNIT_HUNDREDTH  = 2'h1;    // 0.01 s units
  localparam logic [1:0] UNIT_THOUSANDTH = 2'h2;    // 0.001 s units

  ////////////////////////////////////////////////////////////////////////////////
  // Time base
  localparam int CLK_PERIOD_NS   = 8;               // 125 MHz system clock
  localparam int FINE_TICK_NS    = 100000;          // Fine tick, 100 us
  localparam int FINE_CYCLES_DFLT = FINE_TICK_NS / CLK_PERIOD_NS;
  localparam int UNIT_TENTH_NS   = 100000000;       // 0.1 s
  localparam int UNIT_HUND_NS    = 10000000;        // 0.01 s
  localparam int UNIT_THOU_NS    = 1000000;         // 0.001 s
  localparam logic [FRAC_W-1:0] FINE_PER_TENTH = 12'(UNIT_TENTH_NS / FINE_TICK_NS);
  localparam logic [FRAC_W-1:0] FINE_PER_HUND  = 12'(UNIT_HUND_NS / FINE_TICK_NS);
  localparam logic [FRAC_W-1:0] FINE_PER_THOU  = 12'(UNIT_THOU_NS / FINE_TICK_NS);

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers and state
  typedef struct packed {
    logic [ADDR_W-1:0] addr;                        // Word index
    logic [DATA_W-1:0] wdata;                       // Write data
    logic              wr;                          // Write strobe
    logic              rd;                          // Read strobe
  } dlt_bus_req_t;

  typedef struct packed {
    logic              en;                          // Enable (power flow)
    logic              clr;                         // Clear, stopwatch only
    logic              presetUse;                   // Preset operand present
    logic [DATA_W-1:0] preset;                      // Preset operand
  } dlt_tmr_in_t;

  typedef struct packed {
    logic [DATA_W-1:0] cnt;                         // Elapsed count
    logic [DATA_W-1:0] pv;                          // Preset word
    logic              flag;                        // Output flag
    logic              en;                          // Sampled enable
    logic              clr;                         // Sampled clear
  } dlt_timer_t;

  typedef struct packed {
    logic              hitTmr;                      // Index lands in a timer
    logic              hitCfg;                      // Index is the unit select
    logic [1:0]        idx;                         // Timer slot
    logic [1:0]        word;                        // Word within the slot
  } dlt_dec_t;

  typedef struct packed {
    logic [31:0]       cnt;                         // Cycle counter
    logic              tick;                        // Fine tick pulse
  } dlt_tick_state_t;

  typedef struct packed {
    logic [FRAC_W-1:0] frac;                        // Fine ticks in this unit
  } dlt_frac_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic dlt_dec_t addr_decode(input logic [ADDR_W-1:0] a);
    dlt_dec_t d;
    d        = '0;
    d.hitTmr = (a < TMR_WORDS_END);
    d.hitCfg = (a == OFF_UNIT_CFG);
    d.idx    = 2'(a / WORDS_PER_TMR);
    d.word   = 2'(a % WORDS_PER_TMR);
    return d;
  endfunction

  function automatic logic geq(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    return $signed(a) >= $signed(b);
  endfunction

  function automatic logic [FRAC_W-1:0] unit_len(input logic [1:0] sel);
    case (sel)
      UNIT_HUNDREDTH:  unit_len = FINE_PER_HUND;
      UNIT_THOUSANDTH: unit_len = FINE_PER_THOU;
      default:         unit_len = FINE_PER_TENTH;
    endcase
  endfunction

endpackage

// ===== rtl/dlt_tick_gen.sv
`timescale 1ns/1ns
// Free running fine time base: one-cycle pulse every FINE_CYCLES clocks
module dlt_tick_gen #(
  parameter int FINE_CYCLES = dlt_pkg::FINE_CYCLES_DFLT
) (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      fineTick
);

  dlt_pkg::dlt_tick_state_t st_r;                   // Registered state
  dlt_pkg::dlt_tick_state_t st_nxt;                 // Next state

  // Count cycles, pulse at the wrap
  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt == 32'(FINE_CYCLES - 1)) begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt  = st_r.cnt + 32'h0000_0001;
      st_nxt.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fineTick = st_r.tick;

  // Pulse is a single cycle wide
  a_tick_single: assert property (@(posedge clk) disable iff (!reset_n)
    (FINE_CYCLES > 1) && fineTick |=> !fineTick) else $error("fine tick too wide");

endmodule // dlt_tick_gen

// ===== rtl/dlt_frac_scaler.sv
`timescale 1ns/1ns
// Per-timer prescaler: gathers fine ticks into one count unit
module dlt_frac_scaler (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      fineTick,
  input  wire logic [1:0]                unitSel,
  input  wire logic                      run,
  input  wire logic                      clear,
  output logic      [dlt_pkg::FRAC_W-1:0] frac,
  output logic                           unitTick
);

  dlt_pkg::dlt_frac_state_t st_r;                   // Registered fraction
  dlt_pkg::dlt_frac_state_t st_nxt;                 // Next fraction
  logic [dlt_pkg::FRAC_W-1:0] lastFine;             // Fraction value before wrap

  // Unit tick when the last fine tick of a unit lands while running
  always_comb begin
    lastFine = dlt_pkg::unit_len(unitSel) - 12'h001;
    unitTick = run & fineTick & (st_r.frac >= lastFine);
    st_nxt   = st_r;
    if (clear) begin
      st_nxt.frac = '0;
    end else if (unitTick) begin
      st_nxt.frac = '0;
    end else if (run && fineTick) begin
      st_nxt.frac = st_r.frac + 12'h001;
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign frac = st_r.frac;

endmodule // dlt_frac_scaler

// ===== test/dlt_ladder_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Ladder side: drives power flow, clear and preset operand of each rung
module dlt_ladder_model (
  input  wire logic                                   clk,
  output dlt_pkg::dlt_tmr_in_t [dlt_pkg::NUM_TMR-1:0] tmrIn
);
  // All rungs start without power flow
  initial begin
    tmrIn = '0;
  end

  // Change one rung just after a rising edge; preset operand always present
  task automatic setRung(input int idx, input logic en, input logic clr,
                         input logic [15:0] pv);
    @(posedge clk);
    tmrIn[idx].en        <= en;
    tmrIn[idx].clr       <= clr;
    tmrIn[idx].presetUse <= 1'b1;
    tmrIn[idx].preset    <= pv;
  endtask
endmodule // dlt_ladder_model

// ===== test/tb.sv
`timescale 1ns/1ns
module tb;
  logic                                       clk;        // 125 MHz clock
  logic                                       reset_n;    // Active low reset
  dlt_pkg::dlt_bus_req_t                      busReq;     // Register requests
  logic [15:0]                                rdData;     // Read data
  dlt_pkg::dlt_tmr_in_t [dlt_pkg::NUM_TMR-1:0] tmrIn;     // Rung inputs
  logic [2:0]                                 tmrOut;     // Output flags
  logic [15:0]                                val;        // Last read value
  logic [15:0]                                held;       // Frozen count
  int                                         n_mismatch; // Failed compares
  int                                         n_tests;    // All compares

  ////////////////////////////////////////////////////////////////////////////////
  // Short fine tick so one 0.001 s unit is 40 clocks
  dlt_delay_timers #(.FINE_CYCLES(4)) i_dlt_delay_timers (
    .clk(clk), .reset_n(reset_n), .busReq(busReq), .rdData(rdData),
    .tmrIn(tmrIn), .tmrOut(tmrOut));
  dlt_ladder_model i_dlt_ladder_model (.clk(clk), .tmrIn(tmrIn));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    busReq.wr    <= 1'b1;
    busReq.addr  <= a;
    busReq.wdata <= d;
    @(posedge clk);
    busReq.wr    <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle only
  task automatic rdReg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    busReq.rd   <= 1'b1;
    busReq.addr <= a;
    @(posedge clk);
    busReq.rd   <= 1'b0;
    #1 d = rdData;
  endtask

  // Drive a rung and let the timer answer
  task automatic rung(input int i, input logic en, input logic clr, input logic [15:0] pv);
    i_dlt_ladder_model.setRung(i, en, clr, pv);
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Bounded wait for an output flag level
  task automatic waitOut(input int i, input logic lvl);
    int k;
    k = 0;
    while (tmrOut[i] !== lvl && k < 400) begin
      @(posedge clk);
      #1 k++;
    end
    check({15'h0, tmrOut[i]}, {15'h0, lvl}, "flag wait");
  endtask

  // Counts, verdict and end of run
  task automatic results();
    $display("Compares %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog well beyond the few thousand cycles of the tests
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    busReq = '0;
    reset_n = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    // Map and reset values, unmapped index reads zero
    for (int a = 0; a < 10; a++) begin
      rdReg(4'(a), val);
      check(val, (a == 2) ? 16'h4000 : 16'h0000, "reset word");
    end
    rdReg(4'hc, val);
    check(val, 16'h0000, "unmapped");
    wrReg(4'h9, 16'h002a);
    rdReg(4'h9, val);
    check(val, 16'h002a, "unit select");
    @(posedge clk);
    #1 check(rdData, 16'h0000, "read data one cycle");
    wrReg(4'h2, 16'h0fff);
    rdReg(4'h2, val);
    check(val, 16'h4000, "control read-only");
    $display("Test map done");
    // On-delay: flag at preset, cleared when disabled
    rung(1, 1'b1, 1'b0, 16'h0003);
    check({15'h0, tmrOut[1]}, 16'h0000, "ondelay early");
    waitOut(1, 1'b1);
    rdReg(4'h3, val);
    check(val, 16'h0003, "ondelay count");
    rdReg(4'h4, val);
    check(val, 16'h0003, "ondelay preset");
    rung(1, 1'b0, 1'b0, 16'h0003);
    check({15'h0, tmrOut[1]}, 16'h0000, "ondelay off");
    rdReg(4'h3, val);
    check(val, 16'h0000, "ondelay zero");
    $display("Test on-delay done");
    // Unit weight: hundredths, then code 3 taken as tenths
    wrReg(4'h9, 16'h0026);
    rung(1, 1'b1, 1'b0, 16'h0001);
    repeat (300) @(posedge clk);
    #1 check({15'h0, tmrOut[1]}, 16'h0000, "hundredth early");
    waitOut(1, 1'b1);
    rung(1, 1'b0, 1'b0, 16'h0001);
    wrReg(4'h9, 16'h002e);
    rung(1, 1'b1, 1'b0, 16'h0001);
    repeat (3000) @(posedge clk);
    #1 check({15'h0, tmrOut[1]}, 16'h0000, "tenth early");
    repeat (1100) @(posedge clk);
    #1 check({15'h0, tmrOut[1]}, 16'h0001, "tenth reached");
    rung(1, 1'b0, 1'b0, 16'h0001);
    wrReg(4'h9, 16'h002a);
    $display("Test unit select done");
    // Stopwatch: freeze, resume, clear
    rung(0, 1'b1, 1'b0, 16'h0002);
    waitOut(0, 1'b1);
    rung(0, 1'b0, 1'b0, 16'h0002);
    rdReg(4'h0, held);
    repeat (100) @(posedge clk);
    rdReg(4'h0, val);
    check(val, held, "frozen count");
    check({15'h0, tmrOut[0]}, 16'h0001, "frozen flag");
    rung(0, 1'b1, 1'b0, 16'h0002);
    repeat (45) @(posedge clk);
    rdReg(4'h0, val);
    check({15'h0, val > held}, 16'h0001, "resumed");
    rung(0, 1'b1, 1'b1, 16'h0002);
    rdReg(4'h0, val);
    check(val, 16'h0000, "cleared count");
    check({15'h0, tmrOut[0]}, 16'h0000, "cleared flag");
    rung(0, 1'b0, 1'b1, 16'h0000);
    check({15'h0, tmrOut[0]}, 16'h0001, "zero preset");
    // Saturation holds count and flag
    rung(0, 1'b1, 1'b0, 16'h7fff);
    wrReg(4'h0, 16'h7ffe);
    repeat (100) @(posedge clk);
    rdReg(4'h0, val);
    check(val, 16'h7fff, "saturated");
    rung(0, 1'b0, 1'b0, 16'h7fff);
    rdReg(4'h0, val);
    check(val, 16'h7fff, "saturated held");
    check({15'h0, tmrOut[0]}, 16'h0001, "saturated flag");
    $display("Test stopwatch done");
    // Off-delay: on while enabled, drops at preset, restarts
    rung(2, 1'b1, 1'b0, 16'h0002);
    check({15'h0, tmrOut[2]}, 16'h0001, "offdelay on");
    rung(2, 1'b0, 1'b0, 16'h0002);
    check({15'h0, tmrOut[2]}, 16'h0001, "offdelay run");
    waitOut(2, 1'b0);
    repeat (100) @(posedge clk);
    rdReg(4'h6, val);
    check(val, 16'h0002, "offdelay stop");
    rung(2, 1'b1, 1'b0, 16'h0002);
    rdReg(4'h6, val);
    check(val, 16'h0000, "offdelay restart");
    rung(2, 1'b1, 1'b0, 16'h0000);
    check({15'h0, tmrOut[2]}, 16'h0000, "preset zero");
    rung(2, 1'b1, 1'b0, 16'hfffe);
    check({15'h0, tmrOut[2]}, 16'h0000, "preset neg");
    $display("Test off-delay done");
    results();
  end
endmodule // tb
